/* dv/scfg_guard_properties.sv */
// Port level assertions for the sensor channel fault guard
`timescale 1ns/100ps
module scfg_guard_properties (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [3:0] OC_CMP_I,
  input wire logic [3:0] OV_CMP_I,
  input wire logic [3:0] LOW_CMP_I,
  input wire logic [3:0] HIGH_CMP_I,
  input wire logic [3:0] HOT_CMP_I,
  input wire logic [15:0] RDATA_O,
  input wire logic [3:0] STAGE_EN_O,
  input wire logic [3:0] RAIL_CONN_O,
  input wire logic FAULT_SUMMARY_O,
  input wire logic IRQ_O
);
  logic [15:0] mask_sh;
  logic [11:0] on_cnt;
  logic [3:0] stage_q;
  logic [3:0] rail_q;
  logic [3:0] wr_h;
  logic [3:0] rd_h;
  logic [3:0] drop;
  assign drop = stage_q & ~STAGE_EN_O;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // Strobe history covers the register-to-output lag of a control write
  always_ff @(posedge MCLK_I)
  begin
    stage_q <= STAGE_EN_O;
    rail_q <= RAIL_CONN_O;
    wr_h <= {wr_h[2:0], WR_I};
    rd_h <= {rd_h[2:0], RD_I};
    on_cnt <= !STAGE_EN_O[0] ? 12'h000 : on_cnt + {11'h000, on_cnt != 12'hfff};
    if (RST_I)
      mask_sh <= 16'h0000;
    else if (WR_I && ADDR_I == scfg_pkg::ADDR_MASK)
      mask_sh <= WDATA_I;
  end
  rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data not idle");
  mask_read_a: assert property ($past(RD_I) && $past(ADDR_I) == scfg_pkg::ADDR_MASK |-> RDATA_O == $past(mask_sh))
    else $error("mask read back wrong");
  irq_masked_a: assert property (mask_sh == 16'h0000 && $past(mask_sh) == 16'h0000 |-> !IRQ_O)
    else $error("interrupt while all masked");
  stage_cause_a: assert property ((drop & ~(OC_CMP_I | HOT_CMP_I)) != 4'h0 |-> wr_h != 4'h0)
    else $error("stage dropped without cause");
  // Shortest legal run is the blanking time plus three filter steps
  oc_delay_a: assert property (drop[0] && OC_CMP_I[0] && !HOT_CMP_I[0] && wr_h == 4'h0 |-> on_cnt >= 12'd1750)
    else $error("overcurrent shutdown too early");
  oc_hold_a: assert property (drop[0] && wr_h == 4'h0 |-> !STAGE_EN_O[0] [*8])
    else $error("fault shutdown not latched");
  sum_set_a: assert property (drop != 4'h0 && wr_h == 4'h0 |-> ##[0:2] FAULT_SUMMARY_O)
    else $error("summary missing after shutdown");
  sum_clear_a: assert property ($fell(FAULT_SUMMARY_O) |-> rd_h != 4'h0 || wr_h != 4'h0)
    else $error("summary fell without access");
  rail_drop_a: assert property (((rail_q & ~RAIL_CONN_O) & ~(OV_CMP_I | OC_CMP_I | HOT_CMP_I)) != 4'h0 |-> wr_h != 4'h0)
    else $error("rail dropped without cause");
  cover property (drop[0] && OC_CMP_I[0]);
  cover property ($rose(IRQ_O));
  cover property ($fell(FAULT_SUMMARY_O));
endmodule

/* dv/scfg_guard_tb.sv */
// Self-checking bench for the sensor channel fault guard
`timescale 1ns/100ps
module scfg_guard_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [3:0] stage, rail, oc, ov, low, high, hot;
  logic summary, irq;
  scfg_pkg::scfg_cmp_t [3:0] fault = '0;
  scfg_pkg::scfg_cmp_t [3:0] cmp;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int c;
  always #50 mclk = ~mclk;
  always_comb
    for (int i = 0; i < 4; i++)
    begin
      {oc[i], ov[i], low[i], high[i], hot[i]} = cmp[i];
    end
  scfg_guard dut_u (.MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .OC_CMP_I(oc), .OV_CMP_I(ov), .LOW_CMP_I(low), .HIGH_CMP_I(high), .HOT_CMP_I(hot), .RDATA_O(rdata),
    .STAGE_EN_O(stage), .RAIL_CONN_O(rail), .FAULT_SUMMARY_O(summary), .IRQ_O(irq));
  scfg_line_model line_u (.clk_i(mclk), .stage_en_i(stage), .fault_i(fault), .cmp_o(cmp));
  function automatic logic [15:0] all_but(input int ch);
    return {12'h000, 4'hf & ~(4'h1 << ch)};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wreg(input logic [2:0] a, input logic [15:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      test_done;
    end
  end
  initial
  begin
    void'($urandom(81267));
    tick(6);
    rst <= 1'b0;
    rchk(scfg_pkg::ADDR_MASK, scfg_pkg::MASK_RESET);
    d = 16'($urandom);
    wreg(scfg_pkg::ADDR_MASK, d);
    rchk(scfg_pkg::ADDR_MASK, d);
    wreg(scfg_pkg::ADDR_STATUS, 16'hffff);
    rchk(scfg_pkg::ADDR_STATUS, 16'h0000);
    wreg(scfg_pkg::ADDR_MASK, 16'h0001);
    wreg(scfg_pkg::ADDR_CTRL, 16'h000f);
    wreg(scfg_pkg::ADDR_CONFIG, 16'h000f);
    $display("test registers done");
    fault[0].oc <= 1'b1;
    tick(1800);
    chk({12'h000, stage}, 16'h000f);
    for (int i = 0; i < 600 && stage[0]; i++)
      tick(1);
    tick(2);
    chk({12'h000, stage}, all_but(0));
    chk({14'h0000, summary, irq}, 16'h0003);
    rchk(scfg_pkg::ADDR_DATA0, scfg_pkg::GROUND_SHORT_CODE);
    rchk(scfg_pkg::ADDR_STATUS, 16'h0001);
    fault[0].oc <= 1'b0;
    tick(8);
    chk({15'h0000, irq}, 16'h0000);
    rchk(scfg_pkg::ADDR_DATA0, scfg_pkg::GROUND_SHORT_CODE);
    wreg(scfg_pkg::ADDR_CTRL, 16'h000e);
    wreg(scfg_pkg::ADDR_CTRL, 16'h000f);
    tick(4);
    chk({12'h000, stage}, 16'h000f);
    rchk(scfg_pkg::ADDR_DATA0, 16'h0000);
    $display("test overcurrent done");
    c = $urandom_range(3);
    fault[c].ov <= 1'b1;
    tick(40);
    fault[c].ov <= 1'b0;
    tick(20);
    fault[c].ov <= 1'b1;
    tick(40);
    rchk(scfg_pkg::ADDR_DATA0 + 3'(c), 16'h0000);
    tick(40);
    chk({12'h000, rail}, all_but(c));
    chk({12'h000, stage}, 16'h000f);
    fault[c].ov <= 1'b0;
    tick(20);
    rchk(scfg_pkg::ADDR_DATA0 + 3'(c), 16'h0001 << scfg_pkg::FB_BSHORT);
    rchk(scfg_pkg::ADDR_DATA0 + 3'(c), 16'h0000);
    $display("test battery short done");
    for (int k = 0; k < 2; k++)
    begin
      c = $urandom_range(3);
      fault[c].low <= (k == 0);
      fault[c].high <= (k == 1);
      tick(450);
      rchk(scfg_pkg::ADDR_DATA0 + 3'(c), 16'h0000);
      tick(100);
      chk({11'h000, summary, stage}, 16'h001f);
      fault[c] <= '0;
      tick(5);
      if (k == 0)
        rchk(scfg_pkg::ADDR_DATA0 + 3'(c), 16'h0001 << scfg_pkg::FB_OPEN);
      else
      begin
        wreg(scfg_pkg::ADDR_CTRL, all_but(c));
        wreg(scfg_pkg::ADDR_CTRL, 16'h000f);
      end
      rchk(scfg_pkg::ADDR_DATA0 + 3'(c), 16'h0000);
    end
    $display("test open and high current done");
    c = $urandom_range(3);
    fault[c].hot <= 1'b1;
    tick(20);
    fault[c].hot <= 1'b0;
    chk({12'h000, stage}, all_but(c));
    wreg(scfg_pkg::ADDR_CTRL, all_but(c));
    wreg(scfg_pkg::ADDR_CTRL, 16'h000f);
    tick(4);
    rchk(scfg_pkg::ADDR_DATA0 + 3'(c), 16'h0001 << scfg_pkg::FB_THERM);
    chk({12'h000, stage}, all_but(c));
    wreg(scfg_pkg::ADDR_CONFIG, all_but(c));
    wreg(scfg_pkg::ADDR_CONFIG, 16'h000f);
    tick(4);
    rchk(scfg_pkg::ADDR_DATA0 + 3'(c), 16'h0000);
    chk({12'h000, stage}, 16'h000f);
    $display("test thermal done");
    wreg(scfg_pkg::ADDR_CTRL, 16'(16'h0001 << c));
    tick(4);
    chk({12'h000, stage}, 16'(16'h0001 << c));
    $display("test cross link done");
    test_done;
  end
endmodule
bind scfg_guard scfg_guard_properties chk_u (.MCLK_I(MCLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .OC_CMP_I(OC_CMP_I), .OV_CMP_I(OV_CMP_I), .LOW_CMP_I(LOW_CMP_I), .HIGH_CMP_I(HIGH_CMP_I),
  .HOT_CMP_I(HOT_CMP_I), .RDATA_O(RDATA_O), .STAGE_EN_O(STAGE_EN_O), .RAIL_CONN_O(RAIL_CONN_O),
  .FAULT_SUMMARY_O(FAULT_SUMMARY_O), .IRQ_O(IRQ_O));

/* dv/scfg_line_model.sv */
// Remote sensor line model that drives the per channel comparators
`timescale 1ns/100ps
module scfg_line_model (
  input wire logic clk_i,
  input wire logic [3:0] stage_en_i,
  input wire scfg_pkg::scfg_cmp_t [3:0] fault_i,
  output scfg_pkg::scfg_cmp_t [3:0] cmp_o
);
  // Load current only flows while the stage is on; rail and heat faults are external
  always @(posedge clk_i)
    for (int i = 0; i < 4; i++)
    begin
      cmp_o[i].oc <= fault_i[i].oc & stage_en_i[i];
      cmp_o[i].ov <= fault_i[i].ov;
      cmp_o[i].low <= fault_i[i].low;
      cmp_o[i].high <= fault_i[i].high & stage_en_i[i];
      cmp_o[i].hot <= fault_i[i].hot;
    end
endmodule

/* logic/scfg_guard.sv */
// Four channel remote sensor fault guard with register port
`timescale 1ns/100ps
module scfg_guard (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [3:0] OC_CMP_I,
  input wire logic [3:0] OV_CMP_I,
  input wire logic [3:0] LOW_CMP_I,
  input wire logic [3:0] HIGH_CMP_I,
  input wire logic [3:0] HOT_CMP_I,
  output logic [15:0] RDATA_O,
  output logic [3:0] STAGE_EN_O,
  output logic [3:0] RAIL_CONN_O,
  output logic FAULT_SUMMARY_O,
  output logic IRQ_O
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    scfg_pkg::scfg_ch_t [3:0] ch;
    logic [3:0] ctrl_en;
    logic [3:0] cfg_en;
    logic [15:0] status;
    logic [15:0] mask;
    logic [15:0] rdata;
    logic [3:0] stage;
    logic [3:0] rail;
    logic summary;
    logic irq;
    scfg_pkg::scfg_cmp_t [3:0] s1;
    scfg_pkg::scfg_cmp_t [3:0] s2;
    scfg_pkg::scfg_cmp_t [3:0] s3;
    scfg_pkg::scfg_cmp_t [3:0] flt;
  } scfg_state_t;

  scfg_state_t r;
  scfg_state_t next_r;

  function automatic logic [15:0] scfg_pack(input scfg_pkg::scfg_ch_t c);
    logic [15:0] v;
    v = 16'h0000;
    if (c.oc_latch)
      v = scfg_pkg::GROUND_SHORT_CODE;
    v[scfg_pkg::FB_BSHORT] = c.bshort;
    v[scfg_pkg::FB_OPEN] = c.open_f;
    v[scfg_pkg::FB_HICUR] = c.hicur;
    v[scfg_pkg::FB_THERM] = c.therm_latch;
    return v;
  endfunction

  function automatic logic [15:0] scfg_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
  endfunction

  always_comb
  begin
    logic [15:0] ev;
    logic active;
    logic stage_on;
    logic is_read;
    ev = 16'h0000;
    active = 1'b0;
    stage_on = 1'b0;
    is_read = 1'b0;
    next_r = r;
    // ----------------------------------------------------------------
    // Comparator inputs: three flops, change once stages two and three agree
    // ----------------------------------------------------------------
    for (int i = 0; i < scfg_pkg::NUM_CH; i++)
    begin
      next_r.s1[i] = '{OC_CMP_I[i], OV_CMP_I[i], LOW_CMP_I[i], HIGH_CMP_I[i], HOT_CMP_I[i]};
      next_r.s2[i] = r.s1[i];
      next_r.s3[i] = r.s2[i];
      if (r.s2[i] == r.s3[i])
        next_r.flt[i] = r.s3[i];
    end
    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (WR_I)
    begin
      if (ADDR_I == scfg_pkg::ADDR_CTRL)
        next_r.ctrl_en = WDATA_I[3:0];
      else if (ADDR_I == scfg_pkg::ADDR_CONFIG)
        next_r.cfg_en = WDATA_I[3:0];
      else if (ADDR_I == scfg_pkg::ADDR_MASK)
        next_r.mask = WDATA_I;
    end
    // ----------------------------------------------------------------
    // Per channel supervision, each channel sees only its own inputs
    // ----------------------------------------------------------------
    for (int i = 0; i < scfg_pkg::NUM_CH; i++)
    begin
      active = r.ctrl_en[i] & r.cfg_en[i];
      is_read = RD_I && (ADDR_I == 3'(scfg_pkg::ADDR_DATA0 + 3'(i)));
      // Re-enable needs a prior disable seen on the same register
      if (!r.ctrl_en[i])
        next_r.ch[i].ctl_off_seen = 1'b1;
      if (!r.cfg_en[i])
        next_r.ch[i].cfg_off_seen = 1'b1;
      if (r.ctrl_en[i] && r.ch[i].ctl_off_seen)
      begin
        next_r.ch[i].oc_latch = 1'b0;
        next_r.ch[i].ctl_off_seen = 1'b0;
        next_r.ch[i].blank = 16'(scfg_pkg::BLANK_CYC);
        next_r.ch[i].oc_cnt = 8'h00;
      end
      if (r.cfg_en[i] && r.ch[i].cfg_off_seen)
      begin
        next_r.ch[i].therm_latch = 1'b0;
        next_r.ch[i].cfg_off_seen = 1'b0;
      end
      stage_on = active & ~r.ch[i].oc_latch & ~r.ch[i].therm_latch;
      next_r.ch[i].step = scfg_inc(r.ch[i].step);
      if (r.ch[i].blank != scfg_pkg::CNT_ZERO)
        next_r.ch[i].blank = 16'(r.ch[i].blank - 16'h0001);
      // Overcurrent up-down filter in 25 us steps
      if (r.ch[i].step >= 16'(scfg_pkg::OC_STEP_CYC - 1))
      begin
        next_r.ch[i].step = 16'h0000;
        if (stage_on && r.flt[i].oc && r.ch[i].blank == scfg_pkg::CNT_ZERO)
        begin
          if (r.ch[i].oc_cnt >= scfg_pkg::OC_FILT_STEPS - 8'h01)
          begin
            next_r.ch[i].oc_latch = 1'b1;
            ev[i * 4 + 0] = 1'b1;
          end
          else
            next_r.ch[i].oc_cnt = 8'(r.ch[i].oc_cnt + 8'h01);
        end
        else if (r.ch[i].oc_cnt != 8'h00)
          next_r.ch[i].oc_cnt = 8'(r.ch[i].oc_cnt - 8'h01);
      end
      // Battery short up-counter, cleared after 1.5 us absence
      if (active && r.flt[i].ov)
      begin
        next_r.ch[i].sb_gap = 16'h0000;
        if (r.ch[i].step % 16'(scfg_pkg::SB_STEP_CYC) == 16'h0000)
        begin
          if (r.ch[i].sb_cnt >= scfg_pkg::SB_FILT_STEPS - 8'h01)
          begin
            next_r.ch[i].bshort = 1'b1;
            ev[i * 4 + 1] = 1'b1;
          end
          else
            next_r.ch[i].sb_cnt = 8'(r.ch[i].sb_cnt + 8'h01);
        end
      end
      else
      begin
        next_r.ch[i].sb_gap = scfg_inc(r.ch[i].sb_gap);
        if (r.ch[i].sb_gap >= 16'(scfg_pkg::SB_STEP_CYC - 1))
          next_r.ch[i].sb_cnt = 8'h00;
      end
      // Open and high current deglitch, channel keeps running
      next_r.ch[i].open_t = (active && r.flt[i].low) ? scfg_inc(r.ch[i].open_t) : 16'h0000;
      next_r.ch[i].hi_t = (active && r.flt[i].high) ? scfg_inc(r.ch[i].hi_t) : 16'h0000;
      // Thermal shutdown
      if (active && r.flt[i].hot)
      begin
        next_r.ch[i].therm_latch = 1'b1;
        ev[i * 4 + 2] = 1'b1;
      end
      // Clear on read first, so a same-cycle set below wins
      if (is_read || !r.ctrl_en[i])
      begin
        next_r.ch[i].bshort = 1'b0;
        next_r.ch[i].open_f = 1'b0;
        next_r.ch[i].hicur = 1'b0;
      end
      if (ev[i * 4 + 1])
        next_r.ch[i].bshort = 1'b1;
      if (r.ch[i].open_t == 16'(scfg_pkg::OPEN_DEGL_CYC))
      begin
        next_r.ch[i].open_f = 1'b1;
        ev[i * 4 + 3] = 1'b1;
      end
      if (r.ch[i].hi_t == 16'(scfg_pkg::HI_DEGL_CYC))
      begin
        next_r.ch[i].hicur = 1'b1;
        ev[i * 4 + 3] = 1'b1;
      end
      next_r.stage[i] = active & ~next_r.ch[i].oc_latch & ~next_r.ch[i].therm_latch;
      next_r.rail[i] = active & ~next_r.ch[i].bshort;
    end
    // ----------------------------------------------------------------
    // Read data, status and interrupt
    // ----------------------------------------------------------------
    next_r.rdata = 16'h0000;
    if (RD_I)
    begin
      if (ADDR_I == scfg_pkg::ADDR_CTRL)
        next_r.rdata = {12'h000, r.ctrl_en};
      else if (ADDR_I == scfg_pkg::ADDR_CONFIG)
        next_r.rdata = {12'h000, r.cfg_en};
      else if (ADDR_I == scfg_pkg::ADDR_STATUS)
        next_r.rdata = r.status;
      else if (ADDR_I == scfg_pkg::ADDR_MASK)
        next_r.rdata = r.mask;
      else
        next_r.rdata = scfg_pack(r.ch[ADDR_I[1:0]]);
    end
    if (RD_I && ADDR_I == scfg_pkg::ADDR_STATUS)
      next_r.status = ev;
    else
      next_r.status = r.status | ev;
    next_r.summary = 1'b0;
    for (int i = 0; i < scfg_pkg::NUM_CH; i++)
      next_r.summary = next_r.summary | (|scfg_pack(next_r.ch[i]));
    next_r.irq = |(next_r.status & r.mask);
    if (RST_I)
    begin
      next_r = '0;
      next_r.ctrl_en = scfg_pkg::CTRL_RESET;
      next_r.cfg_en = scfg_pkg::CTRL_RESET;
      next_r.mask = scfg_pkg::MASK_RESET;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    r <= next_r;
  end

  assign RDATA_O = r.rdata;
  assign STAGE_EN_O = r.stage;
  assign RAIL_CONN_O = r.rail;
  assign FAULT_SUMMARY_O = r.summary;
  assign IRQ_O = r.irq;
endmodule

/* logic/scfg_pkg.sv */
// Package of constants and types for the sensor channel fault guard
// ----------------------------------------------------------------
// Operation
// - Disable output stage when current stays at limit beyond filter time.
// - Overcurrent filter is an up-down counter stepping every 25 us.
// - Current-limit shutdown writes the ground short code into channel data.
// - Overcurrent latch clears only after channel disable then re-enable.
// - A fault on one channel never affects any other channel.
// - Any channel fault sets the sensor fault summary bit in global status.
// - Overcurrent detection is masked for a blanking time after activation; the code starts blanking only on a ctrl_en re-enable, not on cfg_en.
// - Battery short when output voltage exceeds active rail for filter time.
// - Battery short counter steps every 1.5 us, clears after 1.5 us absence.
// - Battery short disconnects only the affected channel from its rail.
// - Battery short flag clears on data read or channel disable.
// - Open sensor flag when current below 2.5 mA beyond deglitch time.
// - High current flag above 42 mA or 12 mA beyond deglitch time.
// - Open sensor and high current faults never shut the channel down.
// - Open and high current flags clear on data read or channel disable.
// - Over-temperature disables the output stage and latches thermal flag.
// - Thermal flag clears only after disable then re-enable via config.
// ----------------------------------------------------------------
package scfg_pkg;
  localparam int NUM_CH = 4;
  localparam int CLK_NS = 100;
  localparam int OC_STEP_NS = 25000;
  localparam int SB_STEP_NS = 1500;
  // Both filter steps round down, at least one cycle
  localparam int OC_STEP_CYC = (OC_STEP_NS / CLK_NS) < 1 ? 1 : (OC_STEP_NS / CLK_NS);
  localparam int SB_STEP_CYC = (SB_STEP_NS / CLK_NS) < 1 ? 1 : (SB_STEP_NS / CLK_NS);
  localparam logic [7:0] OC_FILT_STEPS = 8'h0004;
  localparam logic [7:0] SB_FILT_STEPS = 8'h0004;
  localparam int BLANK_NS = 100000;
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int OPEN_DEGL_NS = 50000;
  localparam int OPEN_DEGL_CYC = (OPEN_DEGL_NS + CLK_NS - 1) / CLK_NS;
  localparam int HI_DEGL_NS = 50000;
  localparam int HI_DEGL_CYC = (HI_DEGL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_CONFIG = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_MASK = 3'h3;
  localparam logic [2:0] ADDR_DATA0 = 3'h4;
  localparam int FB_GSHORT = 0;
  localparam int FB_BSHORT = 1;
  localparam int FB_OPEN = 2;
  localparam int FB_HICUR = 3;
  localparam int FB_THERM = 4;
  localparam logic [15:0] GROUND_SHORT_CODE = 16'h0001;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  typedef struct packed {
    logic [15:0] step;
    logic [7:0] oc_cnt;
    logic [7:0] sb_cnt;
    logic [15:0] sb_gap;
    logic [15:0] blank;
    logic [15:0] open_t;
    logic [15:0] hi_t;
    logic oc_latch;
    logic therm_latch;
    logic bshort;
    logic open_f;
    logic hicur;
    logic cfg_off_seen;
    logic ctl_off_seen;
  } scfg_ch_t;

  typedef struct packed {
    logic oc;
    logic ov;
    logic low;
    logic high;
    logic hot;
  } scfg_cmp_t;
endpackage
